// >>> dsa_pkg.sv
// dsa_pkg: shared constants and types for the dual simultaneous converter readout
package dsa_pkg;

  // ==========================================================================
  // clock and timing
  localparam int CLK_HZ = 10_000_000;
  localparam real CONV_HS_US = 5.2;
  localparam real CONV_AS_US = 10.0;
  // longest times round down, never below one cycle
  localparam int CONV_HS_CYC_RAW = int'($floor(CONV_HS_US * real'(CLK_HZ) / 1.0E6));
  localparam int CONV_AS_CYC_RAW = int'($floor(CONV_AS_US * real'(CLK_HZ) / 1.0E6));
  localparam int CONV_HS_CYC = (CONV_HS_CYC_RAW < 1) ? 1 : CONV_HS_CYC_RAW;
  localparam int CONV_AS_CYC = (CONV_AS_CYC_RAW < 1) ? 1 : CONV_AS_CYC_RAW;

  // ==========================================================================
  // data layout
  localparam int RES_W = 14;
  localparam int RES_MSB = RES_W - 1;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_W = 4;
  localparam logic [RES_W-1:0] RES_ZERO = 14'h0000;
  localparam logic [RES_W-1:0] SIGN_FLIP = 14'h2000;

  // ==========================================================================
  // sync bit positions within the pin vector
  localparam int PIN_START = 0;
  localparam int PIN_SEL = 1;
  localparam int PIN_CS = 2;
  localparam int PIN_RD = 3;
  localparam logic [SYNC_W-1:0] PIN_IDLE = 4'hD;

  // ==========================================================================
  // types
  typedef struct packed {
    logic rd_n;
    logic cs_n;
    logic pair_select;
    logic convert_start_n;
  } dsa_host_pins_t;

  typedef struct packed {
    logic [RES_W-1:0] result_bus;
    logic result_oe_n;
  } dsa_bus_out_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAKE = 4'h2,
    ST_CONV = 4'h4,
    ST_STORE = 4'h8
  } dsa_state_t;

endpackage : dsa_pkg

// >>> dsa_fifo.sv
// dsa_fifo: result buffer with valid/ready on both sides and a flush
module dsa_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST = (AW)'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign in_ready = (count_r != DEPTH_C);
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // ==========================================================================
  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // ==========================================================================
  // pointers and fill level
  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule : dsa_fifo

// >>> dsa_converter.sv
// dsa_converter: conversion sequencer and parallel readout of a dual sampling converter
module dsa_converter #(
  parameter int RES_W = dsa_pkg::RES_W,
  parameter int FIFO_DEPTH = dsa_pkg::FIFO_DEPTH,
  parameter int CONV_HS_CYC = dsa_pkg::CONV_HS_CYC,
  parameter int CONV_AS_CYC = dsa_pkg::CONV_AS_CYC,
  parameter bit UNIPOLAR = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host pins
  input wire dsa_pkg::dsa_host_pins_t host_pins,
  output logic busy,
  output dsa_pkg::dsa_bus_out_t bus_out,
  // mode strap: high selects auto-sleep
  input wire logic auto_sleep_en,
  // sampled codes from the two quantisers, straight binary
  input wire logic [RES_W-1:0] pair_a_input_one,
  input wire logic [RES_W-1:0] pair_a_input_two,
  input wire logic [RES_W-1:0] pair_b_input_one,
  input wire logic [RES_W-1:0] pair_b_input_two,
  // analog front-end control
  output logic hold,
  output logic asleep
);
  // bit periods: one extra slot for the final latch of each result
  localparam int BIT_SLOTS = RES_W + 1;
  localparam int DIV_RAW = CONV_HS_CYC / BIT_SLOTS;
  localparam int DIV = (DIV_RAW < 1) ? 1 : DIV_RAW;
  localparam int WAKE_RAW = CONV_AS_CYC - CONV_HS_CYC;
  localparam int WAKE = (WAKE_RAW < 1) ? 1 : WAKE_RAW;
  localparam int CW = $clog2(WAKE + DIV + BIT_SLOTS + 1) + 1;
  localparam logic [CW-1:0] DIV_LAST = CW'(DIV - 1);
  localparam logic [CW-1:0] WAKE_LAST = CW'(WAKE - 1);
  localparam logic [CW-1:0] SLOT_LAST = CW'(BIT_SLOTS - 1);

  // ==========================================================================
  // pin synchroniser: three flops, change taken when second and third agree
  logic [dsa_pkg::SYNC_W-1:0] s1_r;
  logic [dsa_pkg::SYNC_W-1:0] s2_r;
  logic [dsa_pkg::SYNC_W-1:0] s3_r;
  logic [dsa_pkg::SYNC_W-1:0] pin_r;
  logic [dsa_pkg::SYNC_W-1:0] pin_prev_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= dsa_pkg::PIN_IDLE;
      s2_r <= dsa_pkg::PIN_IDLE;
      s3_r <= dsa_pkg::PIN_IDLE;
      pin_r <= dsa_pkg::PIN_IDLE;
      pin_prev_r <= dsa_pkg::PIN_IDLE;
    end else begin
      s1_r <= host_pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < dsa_pkg::SYNC_W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          pin_r[i] <= s3_r[i];
        end
      end
      pin_prev_r <= pin_r;
    end
  end

  logic start_fall;
  logic rd_active;
  logic rd_end;
  assign start_fall = pin_prev_r[dsa_pkg::PIN_START] && !pin_r[dsa_pkg::PIN_START];
  assign rd_active = !pin_r[dsa_pkg::PIN_CS] && !pin_r[dsa_pkg::PIN_RD];
  assign rd_end = !pin_prev_r[dsa_pkg::PIN_CS] && !pin_prev_r[dsa_pkg::PIN_RD] && !rd_active;

  // ==========================================================================
  // sequencer
  dsa_pkg::dsa_state_t state_r;
  logic [CW-1:0] div_r;
  logic [CW-1:0] cnt_r;
  logic tick;
  logic store_second_r;
  logic [RES_W-1:0] held_one_r;
  logic [RES_W-1:0] held_two_r;
  logic push_valid;
  logic push_ready;
  logic [RES_W-1:0] push_data;

  assign tick = (div_r == DIV_LAST);

  // internal conversion clock: free divider restarted by each start
  always_ff @(posedge clk) begin
    if (!rst_n || start_fall) begin
      div_r <= '0;
    end else begin
      div_r <= tick ? '0 : div_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= dsa_pkg::ST_IDLE;
      cnt_r <= '0;
      store_second_r <= 1'b0;
    end else begin
      unique case (state_r)
        dsa_pkg::ST_IDLE: begin
          if (start_fall) begin
            cnt_r <= '0;
            store_second_r <= 1'b0;
            state_r <= asleep ? dsa_pkg::ST_WAKE : dsa_pkg::ST_CONV;
          end
        end
        dsa_pkg::ST_WAKE: begin
          // power-up time is what makes the auto-sleep conversion longer
          if (cnt_r == WAKE_LAST) begin
            cnt_r <= '0;
            state_r <= dsa_pkg::ST_CONV;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        dsa_pkg::ST_CONV: begin
          if (tick) begin
            if (cnt_r == SLOT_LAST) begin
              state_r <= dsa_pkg::ST_STORE;
            end else begin
              cnt_r <= cnt_r + 1'b1;
            end
          end
        end
        dsa_pkg::ST_STORE: begin
          // a full buffer stalls here with busy still high
          if (push_ready) begin
            store_second_r <= 1'b1;
            if (store_second_r) begin
              state_r <= dsa_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // starts during a conversion only restart the bit divider; busy already covers them
  assign busy = (state_r != dsa_pkg::ST_IDLE);

  // ==========================================================================
  // sample capture and coding
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      held_one_r <= dsa_pkg::RES_ZERO;
      held_two_r <= dsa_pkg::RES_ZERO;
    end else if (start_fall && state_r == dsa_pkg::ST_IDLE) begin
      if (pin_r[dsa_pkg::PIN_SEL]) begin
        held_one_r <= pair_b_input_one;
        held_two_r <= pair_b_input_two;
      end else begin
        held_one_r <= pair_a_input_one;
        held_two_r <= pair_a_input_two;
      end
    end
  end

  logic [RES_W-1:0] code_one;
  logic [RES_W-1:0] code_two;
  assign code_one = UNIPOLAR ? held_one_r : (held_one_r ^ dsa_pkg::SIGN_FLIP);
  assign code_two = UNIPOLAR ? held_two_r : (held_two_r ^ dsa_pkg::SIGN_FLIP);

  assign push_valid = (state_r == dsa_pkg::ST_STORE);
  assign push_data = store_second_r ? code_two : code_one;

  // hold from the start edge to the end of conversion, track otherwise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold <= 1'b0;
    end else if (start_fall && state_r == dsa_pkg::ST_IDLE) begin
      hold <= 1'b1;
    end else if (state_r == dsa_pkg::ST_STORE && push_ready && store_second_r) begin
      hold <= 1'b0;
    end
  end

  // sleep after each conversion in auto-sleep mode, woken by the next start
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      asleep <= 1'b0;
    end else if (state_r == dsa_pkg::ST_WAKE && cnt_r == WAKE_LAST) begin
      asleep <= 1'b0;
    end else if (state_r == dsa_pkg::ST_STORE && push_ready && store_second_r) begin
      asleep <= auto_sleep_en;
    end else if (state_r == dsa_pkg::ST_IDLE && !auto_sleep_en) begin
      asleep <= 1'b0;
    end
  end

  // ==========================================================================
  // result buffer: flushed by every accepted start
  logic pop_valid;
  logic [RES_W-1:0] pop_data;
  logic flush;
  assign flush = start_fall && state_r == dsa_pkg::ST_IDLE;

  dsa_fifo #(
    .WIDTH(RES_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .flush(flush),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(pop_valid),
    .out_ready(rd_end),
    .out_data(pop_data)
  );

  // ==========================================================================
  // read port: word held for the whole strobe, popped when it ends
  logic [RES_W-1:0] out_word_r;
  logic out_oe_n_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_word_r <= dsa_pkg::RES_ZERO;
      out_oe_n_r <= 1'b1;
    end else begin
      out_oe_n_r <= !rd_active;
      if (rd_active && !(!pin_prev_r[dsa_pkg::PIN_CS] && !pin_prev_r[dsa_pkg::PIN_RD])) begin
        // empty buffer after two reads gives zero, not a stale word
        out_word_r <= pop_valid ? pop_data : dsa_pkg::RES_ZERO;
      end
    end
  end

  assign bus_out.result_bus = out_word_r;
  assign bus_out.result_oe_n = out_oe_n_r;

endmodule : dsa_converter

// >>> dsa_converter_monitor.sv
// dsa_converter_monitor: timing checks on the converter pins
module dsa_converter_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host side
  input wire dsa_pkg::dsa_host_pins_t host_pins,
  input wire logic busy,
  input wire dsa_pkg::dsa_bus_out_t bus_out,
  input wire logic auto_sleep_en,
  // front end
  input wire logic hold,
  input wire logic asleep
);
  // ==========================================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_start;
    $fell(host_pins.convert_start_n) && !busy;
  endsequence
  sequence s_done;
    $fell(busy);
  endsequence
  property p_busy_rise;
    s_start |-> ##[2:8] busy;
  endproperty
  property p_busy_hs;
    $rose(busy) && !auto_sleep_en |-> ##[1:52] !busy;
  endproperty
  property p_busy_as;
    $rose(busy) |-> ##[1:100] !busy;
  endproperty
  property p_hold_in;
    hold |-> busy;
  endproperty
  property p_hold_end;
    s_done |-> $fell(hold);
  endproperty
  property p_sleep;
    s_done |-> asleep == auto_sleep_en;
  endproperty
  property p_oe_on;
    $fell(bus_out.result_oe_n) |-> $past(!host_pins.cs_n && !host_pins.rd_n, 2);
  endproperty
  property p_oe_off;
    $rose(bus_out.result_oe_n) |-> $past(host_pins.rd_n, 2);
  endproperty
  property p_data_hold;
    !bus_out.result_oe_n && $past(!bus_out.result_oe_n) |-> $stable(bus_out.result_bus);
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy late after start");
  a_busy_hs: assert property (p_busy_hs) else $error("high-sampling conversion too long");
  a_busy_as: assert property (p_busy_as) else $error("auto-sleep conversion too long");
  a_hold_in: assert property (p_hold_in) else $error("hold outside conversion");
  a_hold_end: assert property (p_hold_end) else $error("hold not released at end");
  a_sleep: assert property (p_sleep) else $error("sleep state wrong at end");
  a_oe_on: assert property (p_oe_on) else $error("bus driven without strobes");
  a_oe_off: assert property (p_oe_off) else $error("bus released early");
  a_data_hold: assert property (p_data_hold) else $error("data moved while driven");
endmodule : dsa_converter_monitor

bind dsa_converter dsa_converter_monitor i_mon (.clk(clk), .rst_n(rst_n), .host_pins(host_pins),
  .busy(busy), .bus_out(bus_out), .auto_sleep_en(auto_sleep_en), .hold(hold), .asleep(asleep));

// >>> dsa_host_model.sv
// dsa_host_model: host controller driving start, select and read strobes
module dsa_host_model (
  // clock
  input wire logic clk,
  // converter side
  output dsa_pkg::dsa_host_pins_t host_pins,
  input wire logic busy,
  input wire dsa_pkg::dsa_bus_out_t bus_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial host_pins = dsa_pkg::PIN_IDLE;

  // ==========================================================================
  // conversion: select settles long before the start edge
  task convert(input logic sel, output int busy_cyc);
    int n;
    busy_cyc = 0;
    n = 0;
    @(negedge clk);
    host_pins.pair_select = sel;
    // acquisition and quiet time, no reads here
    repeat (10) @(negedge clk);
    host_pins.convert_start_n = 1'b0;
    repeat (4) @(negedge clk);
    host_pins.convert_start_n = 1'b1;
    while (busy !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    // reads wait for the end of conversion
    while (busy === 1'b1 && busy_cyc < 300) begin
      @(negedge clk);
      busy_cyc++;
    end
  endtask : convert

  // ==========================================================================
  // one read pulse with chip-select, held until the bus is driven
  task read(output logic [dsa_pkg::RES_W-1:0] d);
    int n;
    n = 0;
    host_pins.cs_n = 1'b0;
    host_pins.rd_n = 1'b0;
    @(negedge clk);
    while (bus_out.result_oe_n !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    d = bus_out.result_oe_n === 1'b0 ? bus_out.result_bus : 'x;
    host_pins.rd_n = 1'b1;
    host_pins.cs_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask : read
endmodule : dsa_host_model

// >>> tb_dsa_converter.sv
// tb_dsa_converter: self-checking bench for the converter sequencer
module tb_dsa_converter;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic auto_sleep_en = 1'b0;
  logic [13:0] in_a1 = 14'h0123;
  logic [13:0] in_a2 = 14'h3FFF;
  logic [13:0] in_b1 = 14'h2000;
  logic [13:0] in_b2 = 14'h1ABC;
  dsa_pkg::dsa_host_pins_t host_pins;
  dsa_pkg::dsa_bus_out_t bus_out;
  dsa_pkg::dsa_bus_out_t bus_out_uni;
  logic [13:0] uni_word = 14'h0000;
  logic busy;
  logic hold;
  logic asleep;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  always #50 clk = ~clk;

  dsa_converter i_dut (.clk(clk), .rst_n(rst_n), .host_pins(host_pins), .busy(busy), .bus_out(bus_out),
    .auto_sleep_en(auto_sleep_en), .pair_a_input_one(in_a1), .pair_a_input_two(in_a2),
    .pair_b_input_one(in_b1), .pair_b_input_two(in_b2), .hold(hold), .asleep(asleep));
  dsa_host_model i_host (.clk(clk), .host_pins(host_pins), .busy(busy), .bus_out(bus_out));
  // unipolar build on the same pins: same timing, straight binary codes
  dsa_converter #(.UNIPOLAR(1'b1)) i_dut_uni (.clk(clk), .rst_n(rst_n), .host_pins(host_pins), .busy(),
    .bus_out(bus_out_uni), .auto_sleep_en(auto_sleep_en), .pair_a_input_one(in_a1), .pair_a_input_two(in_a2),
    .pair_b_input_one(in_b1), .pair_b_input_two(in_b2), .hold(), .asleep());

  // last word the unipolar build drove, taken only while it drives
  always @(negedge clk) begin
    if (bus_out_uni.result_oe_n === 1'b0) begin
      uni_word = bus_out_uni.result_bus;
    end
  end

  // ==========================================================================
  // shared helpers
  function automatic logic [13:0] code(input logic [13:0] x);
    return x ^ dsa_pkg::SIGN_FLIP;
  endfunction : code

  task check(input logic [13:0] seen, input logic [13:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task final_report;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // ==========================================================================
  // scenarios
  task t_pair_a;
    int bc;
    logic [13:0] d;
    auto_sleep_en = 1'b0;
    i_host.convert(1'b0, bc);
    check(14'(bc > 0), 14'h1);
    check(14'(bc <= dsa_pkg::CONV_HS_CYC), 14'h1);
    check(14'(hold), 14'h0);
    check(14'(asleep), 14'h0);
    i_host.read(d);
    check(d, code(in_a1));
    check(uni_word, in_a1);
    i_host.read(d);
    check(d, code(in_a2));
    check(uni_word, in_a2);
    check(14'(bus_out.result_oe_n), 14'h1);
    $display("t_pair_a done");
  endtask : t_pair_a

  task t_pair_b;
    int bc;
    logic [13:0] d;
    auto_sleep_en = 1'b1;
    // first pass starts awake, the second has to wake up before converting
    repeat (2) begin
      i_host.convert(1'b1, bc);
      check(14'(bc > 0), 14'h1);
      check(14'(bc <= dsa_pkg::CONV_AS_CYC), 14'h1);
      check(14'(asleep), 14'h1);
      i_host.read(d);
      check(d, code(in_b1));
      i_host.read(d);
      check(d, code(in_b2));
    end
    auto_sleep_en = 1'b0;
    $display("t_pair_b done");
  endtask : t_pair_b

  task t_restart;
    int bc;
    logic [13:0] d;
    i_host.convert(1'b0, bc);
    i_host.read(d);
    check(d, code(in_a1));
    in_a1 = 14'h1555;
    i_host.convert(1'b0, bc);
    check(14'(asleep), 14'h0);
    i_host.read(d);
    check(d, code(in_a1));
    i_host.read(d);
    check(d, code(in_a2));
    $display("t_restart done");
  endtask : t_restart

  // ==========================================================================
  // hang guard and main sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      $display("[ERR] %0t run timed out", $time);
      final_report();
    end
  end

  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_pair_a();
    t_pair_b();
    t_restart();
    final_report();
  end
endmodule : tb_dsa_converter
